// ==== hw/rss_pkg.sv ====
// Package of constants for the reset and start-up sequencer
package rss_pkg;

   // ****************************************
   // Timing
   // ****************************************
   localparam int unsigned CLK_PERIOD_NS     = 10;
   localparam int unsigned PWRUP_DELAY_MS    = 64;
   localparam int unsigned PWRUP_DELAY_CYC   =
      (PWRUP_DELAY_MS * 1000000) / CLK_PERIOD_NS;
   localparam int unsigned MASTER_CLEAR_PIN_EXEC_CYC     = 10;

   // ****************************************
   // Status register fields and reset values
   // ****************************************
   localparam int unsigned STAT_W            = 2;
   localparam int unsigned STAT_OVF_BIT      = 1;
   localparam int unsigned STAT_UNF_BIT      = 0;
   localparam logic [1:0]  STAT_RESET_VAL    = 2'h0;

   // ****************************************
   // Sequencer states
   // ****************************************
   typedef enum logic [4:0] {
      RSS_POWER_HOLD = 5'h01,
      RSS_PWRUP_WAIT = 5'h02,
      RSS_OSC_WAIT   = 5'h04,
      RSS_MASTER_CLEAR_PIN_WAIT  = 5'h08,
      RSS_RUN        = 5'h10
   } rss_state_t;

endpackage

// ==== hw/rss_reset_startup_sequencer.sv ====
// Reset and start-up sequencer that holds the core until release
//
// Functional notes
// RULE1 - Stack fault causes device reset when enabled
// RULE2 - Overflow and underflow latched in separate flags
// RULE3 - Stack faults ignored while enable bit clear
// RULE4 - Programming mode exit behaves like power-on
// RULE5 - Self-programming and erase never reset device
// RULE6 - Power-up delay lasts 64 ms nominal
// RULE7 - Core held in reset during power-up delay
// RULE8 - Delay enabled when active-low enable clear
// RULE9 - Delay starts after power-on and brownout release
// RULE10 - Wait delay, oscillator start-up, master-clear release
// RULE11 - Timers run regardless of master-clear level
// RULE12 - Execution starts 10 cycles after master-clear rises
// RULE13 - Oscillator ready input from clock block
`timescale 1ns/1ns
`default_nettype none

module rss_reset_startup_sequencer #(
   parameter int unsigned PWRUP_CYC = rss_pkg::PWRUP_DELAY_CYC,
   parameter int unsigned EXEC_CYC  = rss_pkg::MASTER_CLEAR_PIN_EXEC_CYC
) (
   // Clock and synchronous reset
   input  wire logic       core_clk,
   input  wire logic       rst_n,
   // Power supervisors, high while condition holds
   input  wire logic       power_on_reset,
   input  wire logic       brownout_reset,
   // External reset pin and its enable
   input  wire logic       master_clear_pin,
   input  wire logic       master_clear_enable,
   // Programming mode, high while in serial programming
   input  wire logic       serial_programming_mode,
   // Core stack fault events, one-cycle pulses
   input  wire logic       stack_overflow_event,
   input  wire logic       stack_underflow_event,
   // Configuration
   input  wire logic       stack_fault_reset_enable,
   input  wire logic       power_up_delay_enable_n,
   // Clock block start-up status
   input  wire logic       osc_startup_done,
   // Status flag clear from software, one-cycle pulses
   input  wire logic       clear_overflow_flag,
   input  wire logic       clear_underflow_flag,
   // Outputs
   output logic            core_reset_n,
   output logic            stack_overflow_flag,
   output logic            stack_underflow_flag,
   output logic [rss_pkg::STAT_W-1:0] power_control_status_reg
);

   // ****************************************
   // Counter sizing
   // ****************************************
   localparam int unsigned PW = $clog2(PWRUP_CYC + 1);
   localparam int unsigned EW = $clog2(EXEC_CYC + 1);
   localparam logic [PW-1:0] PWRUP_LAST = PW'(PWRUP_CYC - 1);
   localparam logic [EW-1:0] EXEC_LAST  = EW'(EXEC_CYC - 1);

   // ****************************************
   // State
   // ****************************************
   rss_pkg::rss_state_t state;
   rss_pkg::rss_state_t next_state;
   logic [PW-1:0]       pwrup_cnt;
   logic [EW-1:0]       exec_cnt;
   logic                pwrup_done;
   logic                exec_done;

   // ****************************************
   // Reset source decode
   // ****************************************
   wire stack_fault_hit = stack_fault_reset_enable &        // RULE3
      (stack_overflow_event | stack_underflow_event);       // RULE1
   // Cold sources restart the whole sequence; note that
   // self-programming has no input here so cannot reset
   wire cold_hold = power_on_reset | brownout_reset       // RULE9
      | serial_programming_mode;                            // RULE4 RULE5
   wire master_clear_pin_low = master_clear_enable & ~master_clear_pin;
   wire pwrup_on = ~power_up_delay_enable_n;                // RULE8
   wire pwrup_ok = ~pwrup_on | pwrup_done;
   wire osc_ok   = osc_startup_done;                        // RULE13
   wire timers_ok = pwrup_ok & osc_ok;                      // RULE10
   wire next_ovf = ~stack_overflow_flag & clear_overflow_flag ? 1'b0 :
      stack_overflow_flag & ~clear_overflow_flag;
   wire set_ovf  = stack_fault_reset_enable & stack_overflow_event;
   wire set_unf  = stack_fault_reset_enable & stack_underflow_event;

   // ****************************************
   // Sequencer next state
   // ****************************************
   always_comb begin
      next_state = state;
      case (state)
         rss_pkg::RSS_POWER_HOLD: begin
            next_state = rss_pkg::RSS_PWRUP_WAIT;           // RULE9
         end
         rss_pkg::RSS_PWRUP_WAIT: begin
            if (pwrup_ok) begin                             // RULE7
               next_state = rss_pkg::RSS_OSC_WAIT;
            end
         end
         rss_pkg::RSS_OSC_WAIT: begin
            if (osc_ok) begin                               // RULE10
               next_state = rss_pkg::RSS_MASTER_CLEAR_PIN_WAIT;
            end
         end
         rss_pkg::RSS_MASTER_CLEAR_PIN_WAIT: begin
            if (exec_done) begin                            // RULE12
               next_state = rss_pkg::RSS_RUN;
            end
         end
         rss_pkg::RSS_RUN: begin
            if (master_clear_pin_low | stack_fault_hit) begin           // RULE1
               next_state = rss_pkg::RSS_MASTER_CLEAR_PIN_WAIT;
            end
         end
         default: begin
            next_state = rss_pkg::RSS_POWER_HOLD;
         end
      endcase
      if (cold_hold) begin
         next_state = rss_pkg::RSS_POWER_HOLD;              // RULE4
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         state <= rss_pkg::RSS_POWER_HOLD;
      end else begin
         state <= next_state;
      end
   end

   // ****************************************
   // Power-up delay timer
   // ****************************************
   // Counts independently of master-clear once power is good
   always_ff @(posedge core_clk) begin
      if (!rst_n || cold_hold) begin
         pwrup_cnt  <= '0;
         pwrup_done <= 1'b0;
      end else if (pwrup_on && !pwrup_done &&
                   state != rss_pkg::RSS_POWER_HOLD) begin // RULE11
         pwrup_cnt  <= pwrup_cnt + PW'(1);
         pwrup_done <= (pwrup_cnt == PWRUP_LAST);           // RULE6
      end
   end

   // ****************************************
   // Master-clear to execution delay
   // ****************************************
   // Restarts on a low master-clear while enabled or a stack fault; counts only once
   // both start-up timers have expired
   always_ff @(posedge core_clk) begin
      if (!rst_n || cold_hold || master_clear_pin_low || stack_fault_hit ||
          state != rss_pkg::RSS_MASTER_CLEAR_PIN_WAIT || !timers_ok) begin
         exec_cnt  <= '0;
         exec_done <= 1'b0;
      end else if (!exec_done) begin
         exec_cnt  <= exec_cnt + EW'(1);
         exec_done <= (exec_cnt == EXEC_LAST);              // RULE12
      end
   end

   // ****************************************
   // Core reset output
   // ****************************************
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         core_reset_n <= 1'b0;
      end else begin
         core_reset_n <= (next_state == rss_pkg::RSS_RUN);  // RULE7
      end
   end

   // ****************************************
   // Stack fault status flags
   // ****************************************
   // Set wins over a clear in the same cycle
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         stack_overflow_flag  <= 1'b0;
         stack_underflow_flag <= 1'b0;
         power_control_status_reg <= rss_pkg::STAT_RESET_VAL;
      end else begin
         stack_overflow_flag  <= set_ovf |
            (stack_overflow_flag & ~clear_overflow_flag);   // RULE2
         stack_underflow_flag <= set_unf |
            (stack_underflow_flag & ~clear_underflow_flag); // RULE2
         power_control_status_reg[rss_pkg::STAT_OVF_BIT] <= set_ovf |
            (stack_overflow_flag & ~clear_overflow_flag);
         power_control_status_reg[rss_pkg::STAT_UNF_BIT] <= set_unf |
            (stack_underflow_flag & ~clear_underflow_flag);
      end
   end

   // Spare decode kept out of use
   wire unused_ok = next_ovf;

endmodule

`default_nettype wire

// ==== tb/rss_checker_sva.sv ====
// Checker for the reset and start-up sequencer
`timescale 1ns/1ns
`default_nettype none
module rss_checker (
   // Clock, reset and inputs
   input wire logic       core_clk,
   input wire logic       rst_n,
   input wire logic       serial_programming_mode,
   input wire logic       master_clear_pin,
   input wire logic       master_clear_enable,
   input wire logic       stack_overflow_event,
   input wire logic       stack_underflow_event,
   input wire logic       stack_fault_reset_enable,
   // Outputs
   input wire logic       core_reset_n,
   input wire logic       stack_overflow_flag,
   input wire logic       stack_underflow_flag,
   input wire logic [1:0] power_control_status_reg
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   sequence s_pin_up;
      master_clear_enable && $rose(master_clear_pin) ##1 master_clear_pin[*8];
   endsequence
   a_ovf_flag: assert property (stack_overflow_event &&
      stack_fault_reset_enable |=> stack_overflow_flag) else $error("ovf flag");
   a_unf_flag: assert property (stack_underflow_event &&
      stack_fault_reset_enable |=> stack_underflow_flag) else $error("unf flag");
   a_fault_off: assert property (stack_overflow_event &&
      !stack_fault_reset_enable && !stack_overflow_flag |=>
      !stack_overflow_flag) else $error("flag set while disabled");
   a_fault_reset: assert property ((stack_overflow_event ||
      stack_underflow_event) && stack_fault_reset_enable |=> !core_reset_n)
      else $error("fault did not reset core");
   a_pin_hold: assert property (master_clear_enable &&
      !master_clear_pin |=> !core_reset_n) else $error("pin did not hold");
   a_prog_hold: assert property (serial_programming_mode |=>
      !core_reset_n) else $error("core ran in programming mode");
   a_exec_early: assert property (s_pin_up |-> !core_reset_n)
      else $error("core released too early");
   a_stat_mirror: assert property (power_control_status_reg ==
      {stack_overflow_flag, stack_underflow_flag}) else $error("status");
endmodule
`default_nettype wire

// ==== tb/rss_core_model.sv ====
// Core model that raises stack fault pulses while running
`timescale 1ns/1ns
`default_nettype none
module rss_core_model (
   // Clock and hold
   input  wire logic core_clk,
   input  wire logic core_reset_n,
   // Fault requests from the bench
   input  wire logic ovf_req,
   input  wire logic unf_req,
   // Fault pulses
   output logic      stack_overflow_event,
   output logic      stack_underflow_event
);
   // A held core cannot push or pop
   always_ff @(posedge core_clk) begin
      stack_overflow_event  <= ovf_req & core_reset_n;
      stack_underflow_event <= unf_req & core_reset_n;
   end
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// Testbench for the reset and start-up sequencer
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic core_clk, rst_n, power_on_reset, brownout_reset, ovf_req, unf_req;
   logic master_clear_pin, master_clear_enable, serial_programming_mode;
   logic stack_overflow_event, stack_underflow_event, osc_startup_done;
   logic stack_fault_reset_enable, power_up_delay_enable_n, core_reset_n;
   logic clear_overflow_flag, clear_underflow_flag;
   logic stack_overflow_flag, stack_underflow_flag;
   logic [1:0] power_control_status_reg;
   int fails, n_checks, n;
   rss_reset_startup_sequencer #(.PWRUP_CYC(20)) uut (.*);
   rss_core_model core (.*);
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   task automatic chk(string s, logic [1:0] e, logic [1:0] g);
      n_checks++;
      if (g !== e) begin
         fails++;
         $display("unexpected %s exp %h got %h", s, e, g);
      end
   endtask
   task automatic rel;
      n = 0;
      while (core_reset_n !== 1'b1 && n < 99) begin
         @(negedge core_clk);
         n++;
      end
   endtask
   task automatic boot(logic [2:0] src, logic dn, logic [1:0] init, int wt);
      @(posedge core_clk);
      {power_on_reset, brownout_reset, serial_programming_mode} <= src;
      power_up_delay_enable_n <= dn;
      repeat (2) @(posedge core_clk);
      {power_on_reset, brownout_reset, serial_programming_mode} <= 3'h0;
      {osc_startup_done, master_clear_pin} <= init;
      repeat (wt + 1) @(negedge core_clk);
      chk("held", 2'h0, {1'b0, core_reset_n});
      @(posedge core_clk);
      {osc_startup_done, master_clear_pin} <= 2'h3;
      rel;
      chk("boot", 2'h1, {1'b0, wt ? (n >= 10 && n <= 13)
         : (dn ? n < 20 : n > 20)});
   endtask
   task automatic fault(logic en, logic ov);
      @(posedge core_clk);
      stack_fault_reset_enable <= en;
      {ovf_req, unf_req} <= {ov, !ov};
      @(posedge core_clk);
      {ovf_req, unf_req} <= 2'h0;
      repeat (2) @(negedge core_clk);
      chk("stat", en ? {ov, !ov} : 2'h0, power_control_status_reg);
      chk("run", {1'b0, !en}, {1'b0, core_reset_n});
      rel;
      @(posedge core_clk);
      {clear_overflow_flag, clear_underflow_flag} <= 2'h3;
      @(posedge core_clk);
      {clear_overflow_flag, clear_underflow_flag} <= 2'h0;
   endtask
   task automatic pin_t(logic pe);
      @(posedge core_clk);
      {master_clear_enable, master_clear_pin} <= {pe, 1'b0};
      repeat (30) @(negedge core_clk);
      chk("pin", {1'b0, !pe}, {1'b0, core_reset_n});
      @(posedge core_clk);
      master_clear_pin <= 1'b1;
      rel;
      chk("exec", 2'h1, {1'b0, (!pe || n >= 10) && n <= 12});
   endtask
   task automatic conclude;
      if (fails == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial begin
      {rst_n, power_on_reset, brownout_reset, serial_programming_mode} = 0;
      {ovf_req, unf_req, clear_overflow_flag, clear_underflow_flag} = 0;
      {master_clear_pin, osc_startup_done, power_up_delay_enable_n} = 0;
      {master_clear_enable, stack_fault_reset_enable} = 2'h3;
      fails = 0;
      n_checks = 0;
      repeat (4) @(posedge core_clk);
      rst_n <= 1'b1;
      boot(3'h4, 1'b0, 2'h0, 0);
      boot(3'h2, 1'b1, 2'h0, 0);
      boot(3'h1, 1'b0, 2'h0, 0);
      boot(3'h4, 1'b0, 2'h2, 25);
      boot(3'h4, 1'b1, 2'h1, 25);
      fault(1'b1, 1'b1);
      fault(1'b1, 1'b0);
      fault(1'b0, 1'b1);
      pin_t(1'b0);
      pin_t(1'b1);
      conclude;
   end
   initial begin
      #20000;
      fails++;
      conclude;
   end
endmodule
bind rss_reset_startup_sequencer rss_checker chk_i (.*);
`default_nettype wire
